// File: rtl/ext_bus_pkg.sv
// shared widths and reset values for the external bus pin control
package ext_bus_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 23;     // full program address width
  localparam int ADDR_LO_W = 16;  // lines shared by all spaces
  localparam int DATA_W = 16;     // data bus width
  localparam int SYNC_STAGES = 2; // flip-flops on every pin input

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic KEEPER_EN_RST = 1'b0;     // keepers off after reset
  localparam logic PIN_ACTIVE_LOW_RST = 1'b0; // pin syncs start asserted
  localparam logic PIN_IDLE_HIGH_RST = 1'b1;  // idle-high pins start high
  localparam logic HOLD_ACK_RST = 1'b0;       // no hold granted
  localparam logic IRQ_ACKNOWLEDGE_N_IDLE = 1'b1;          // acknowledge idles high

endpackage

// File: rtl/pin_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
module pin_sync
  import ext_bus_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic RST_VAL = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  initial begin
    if (WIDTH < 1) $error("pin_sync width must be at least one");
  end

  // first stage is read only by the second
  always_comb begin
    meta_d = pin_in;
    sync_d = meta_q;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {WIDTH{RST_VAL}};
      sync_q <= {WIDTH{RST_VAL}};
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

// File: rtl/ext_bus_pins.sv
// external address/data bus and interrupt acknowledge pin control
//
// How it works
// - every external access drives its address on the low sixteen address lines.
// - the upper seven address lines are driven only for program-space accesses.
// - all address lines float in hold mode or while output-disable is low.
// - one sixteen-bit two-way data bus serves program, data and I/O transfers.
// - the data bus floats when not writing, in reset, and while hold is requested.
// - the data bus also floats whenever output-disable is low.
// - with keepers on and no drive, each data line keeps its last level.
// - the keepers are off after reset until software turns them on.
// - software turns the keepers on or off with one bank-switch control bit.
// - acknowledge goes low during a vector fetch whose address is on the low lines.
// - acknowledge floats whenever output-disable is low.
`timescale 1ns/10ps
module ext_bus_pins
  import ext_bus_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int ALW = ADDR_LO_W,
  parameter int DW = DATA_W
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  // core side, same clock
  input wire logic core_access,
  input wire logic core_write,
  input wire logic core_prog_space,
  input wire logic core_vector_fetch,
  input wire logic [AW-1:0] core_addr,
  input wire logic [DW-1:0] core_wdata,
  output logic [DW-1:0] core_rdata,
  input wire logic bank_switch_control_wr,
  input wire logic data_keeper_enable,
  output logic keeper_enabled,
  // pins in from outside
  input wire logic reset_in_n,
  input wire logic hold_req_n,
  input wire logic output_disable_n,
  // address pins
  output logic [AW-1:0] ext_address_bus_o,
  output logic ext_address_lo_oe,
  output logic ext_address_hi_oe,
  // data pins
  input wire logic [DW-1:0] ext_data_bus_i,
  output logic [DW-1:0] ext_data_bus_o,
  output logic ext_data_bus_oe,
  output logic ext_data_keep_en,
  // hold grant and acknowledge
  output logic hold_ack_n,
  output logic irq_acknowledge_n,
  output logic irq_acknowledge_oe
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  initial begin
    if (ALW < 1 || ALW > AW) $error("low address width out of range");
    if (DW < 1) $error("data width must be at least one");
  end

  // ----------------------------------------------------------------
  // pin input synchronisers
  // ----------------------------------------------------------------
  logic reset_in_s;
  logic hold_req_s;
  logic off_s;
  logic [DW-1:0] data_in_s;

  // reset pin starts asserted so the data bus floats until it is seen high
  pin_sync #(.WIDTH(1), .RST_VAL(PIN_ACTIVE_LOW_RST)) u_sync_rst (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_in(reset_in_n),
    .sync_out(reset_in_s)
  );

  pin_sync #(.WIDTH(1), .RST_VAL(PIN_IDLE_HIGH_RST)) u_sync_hold (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_in(hold_req_n),
    .sync_out(hold_req_s)
  );

  // output-disable starts low: nothing drives until it is released
  pin_sync #(.WIDTH(1), .RST_VAL(PIN_ACTIVE_LOW_RST)) u_sync_off (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_in(output_disable_n),
    .sync_out(off_s)
  );

  pin_sync #(.WIDTH(DW), .RST_VAL(PIN_ACTIVE_LOW_RST)) u_sync_data (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_in(ext_data_bus_i),
    .sync_out(data_in_s)
  );

  // ----------------------------------------------------------------
  // keeper control and hold grant
  // ----------------------------------------------------------------
  logic keeper_en_q;
  logic keeper_en_d;
  logic hold_ack_q;
  logic hold_ack_d;
  // active-low copy so the grant pin leaves straight from a flop
  logic hold_ack_n_q;
  logic hold_ack_n_d;

  always_comb begin
    keeper_en_d = keeper_en_q;
    if (bank_switch_control_wr) begin
      keeper_en_d = data_keeper_enable;
    end
    // grant only between accesses so no transfer is cut in half
    hold_ack_d = !hold_req_s && (hold_ack_q || !core_access);
    hold_ack_n_d = !hold_ack_d;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      keeper_en_q <= KEEPER_EN_RST;
      hold_ack_q <= HOLD_ACK_RST;
      hold_ack_n_q <= !HOLD_ACK_RST;
    end else begin
      keeper_en_q <= keeper_en_d;
      hold_ack_q <= hold_ack_d;
      hold_ack_n_q <= hold_ack_n_d;
    end
  end

  // ----------------------------------------------------------------
  // float terms and pin drive
  // ----------------------------------------------------------------
  logic float_addr;
  logic float_data;
  logic [AW-1:0] addr_q;
  logic [AW-1:0] addr_d;
  logic addr_lo_oe_q;
  logic addr_lo_oe_d;
  logic addr_hi_oe_q;
  logic addr_hi_oe_d;
  logic [DW-1:0] data_o_q;
  logic [DW-1:0] data_o_d;
  logic data_oe_q;
  logic data_oe_d;
  logic keep_en_q;
  logic keep_en_d;
  logic irq_acknowledge_n_q;
  logic irq_acknowledge_n_d;
  logic irq_acknowledge_n_oe_q;
  logic irq_acknowledge_n_oe_d;
  logic [DW-1:0] rdata_q;
  logic [DW-1:0] rdata_d;

  // one OR per pin group, no priority between the float causes
  always_comb begin
    float_addr = !off_s || hold_ack_q;
    // hold request alone floats data, even before the grant
    float_data = float_addr || !reset_in_s || !hold_req_s;
    addr_d = addr_q;
    if (core_access) begin
      addr_d = core_addr;
    end
    addr_lo_oe_d = !float_addr;
    addr_hi_oe_d = !float_addr && core_access && core_prog_space;
    data_oe_d = !float_data && core_access && core_write;
    // keeper register: tracks what was driven, else what the bus showed
    data_o_d = data_oe_d ? core_wdata : (data_oe_q ? data_o_q : data_in_s);
    if (keep_en_q) begin
      data_o_d = data_oe_d ? core_wdata : data_o_q;
    end
    keep_en_d = keeper_en_q && !data_oe_d;
    irq_acknowledge_n_d = !(core_access && core_vector_fetch);
    irq_acknowledge_n_oe_d = off_s;
    rdata_d = data_in_s;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= '0;
      addr_lo_oe_q <= 1'b0;
      addr_hi_oe_q <= 1'b0;
      data_o_q <= '0;
      data_oe_q <= 1'b0;
      keep_en_q <= KEEPER_EN_RST;
      irq_acknowledge_n_q <= IRQ_ACKNOWLEDGE_N_IDLE;
      irq_acknowledge_n_oe_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      addr_q <= addr_d;
      addr_lo_oe_q <= addr_lo_oe_d;
      addr_hi_oe_q <= addr_hi_oe_d;
      data_o_q <= data_o_d;
      data_oe_q <= data_oe_d;
      keep_en_q <= keep_en_d;
      irq_acknowledge_n_q <= irq_acknowledge_n_d;
      irq_acknowledge_n_oe_q <= irq_acknowledge_n_oe_d;
      rdata_q <= rdata_d;
    end
  end

  assign ext_address_bus_o = addr_q;
  assign ext_address_lo_oe = addr_lo_oe_q;
  assign ext_address_hi_oe = addr_hi_oe_q;
  assign ext_data_bus_o = data_o_q;
  assign ext_data_bus_oe = data_oe_q;
  assign ext_data_keep_en = keep_en_q;
  assign hold_ack_n = hold_ack_n_q;
  assign irq_acknowledge_n = irq_acknowledge_n_q;
  assign irq_acknowledge_oe = irq_acknowledge_n_oe_q;
  assign core_rdata = rdata_q;
  assign keeper_enabled = keeper_en_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_lo_addr_follows: assert property (@(posedge sys_clk) disable iff (!rst_n)
    core_access |=> ext_address_bus_o[ALW-1:0] == $past(core_addr[ALW-1:0]))
    else $error("low address lines do not follow the access");

  a_hi_addr_prog: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ext_address_hi_oe |-> $past(core_prog_space) && $past(core_access))
    else $error("upper address driven outside a program access");

  a_addr_float: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!off_s || hold_ack_q) |=> !ext_address_lo_oe && !ext_address_hi_oe)
    else $error("address driven while floated");

  a_data_write_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ext_data_bus_oe |-> $past(core_write) && $past(core_access)
      && ext_data_bus_o == $past(core_wdata))
    else $error("data bus driven without a write");

  a_data_float_rst: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!reset_in_s || !hold_req_s) |=> !ext_data_bus_oe)
    else $error("data bus driven during reset or hold");

  a_data_float_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !off_s |=> !ext_data_bus_oe && !irq_acknowledge_oe)
    else $error("data or acknowledge driven while output disabled");

  a_keeper_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ext_data_keep_en && !ext_data_bus_oe) ##1 !ext_data_bus_oe
      |-> $stable(ext_data_bus_o))
    else $error("kept data level changed");

  a_keeper_sw: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bank_switch_control_wr |=> keeper_enabled == $past(data_keeper_enable))
    else $error("keeper bit not updated by write");

  a_keeper_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !bank_switch_control_wr |=> $stable(keeper_enabled))
    else $error("keeper bit changed without a write");

  a_irq_acknowledge_n_fetch: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (core_access && core_vector_fetch) |=> !irq_acknowledge_n
      && ext_address_bus_o[ALW-1:0] == $past(core_addr[ALW-1:0]))
    else $error("acknowledge missing on vector fetch");

  a_irq_acknowledge_n_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(core_access && core_vector_fetch) |=> irq_acknowledge_n)
    else $error("acknowledge low outside a vector fetch");

  a_hold_grant: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!hold_req_s && !core_access) |=> !hold_ack_n ##1 !ext_address_lo_oe)
    else $error("hold not granted and floated");

endmodule

// File: verif/ext_mem_model.sv
// external memory model with data-wire resolution
`timescale 1ns/10ps
module ext_mem_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic mem_drive,
  input wire logic [15:0] addr_lo,
  input wire logic [15:0] data_o,
  input wire logic data_oe,
  input wire logic keep_en,
  output logic [15:0] data_wire
);
  logic [15:0] last_q;
  // ----------------------------------------
  // wire level
  // ----------------------------------------
  // a released wire toggles, so a missing keeper cannot pass by luck
  assign data_wire = data_oe ? data_o :
    mem_drive ? (addr_lo ^ 16'h5a5a) :
    keep_en ? data_o : ~last_q;
  // last wire level, for the released pattern
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_q <= 16'h0000;
    end else begin
      last_q <= data_wire;
    end
  end
endmodule

// File: verif/external_bus_pin_control_test.sv
// self-checking bench for the external bus pin control
`timescale 1ns/10ps
module external_bus_pin_control_test;
  import ext_bus_pkg::*;
  logic sys_clk, rst_n, acc, wr, prog, vec, ks_wr, ks_val, pin_rst_n, hold_n, off_n;
  logic mem_drive, keeper_on, lo_oe, hi_oe, d_oe, keep_en, hack_n, irq_acknowledge_n_n, irq_acknowledge_n_oe, kept;
  logic [ADDR_W-1:0] addr, addr_o;
  logic [DATA_W-1:0] wdata, rdata, dbus_i, dbus_o;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;

  ext_bus_pins i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .core_access(acc), .core_write(wr),
    .core_prog_space(prog), .core_vector_fetch(vec), .core_addr(addr), .core_wdata(wdata),
    .core_rdata(rdata), .bank_switch_control_wr(ks_wr), .data_keeper_enable(ks_val),
    .keeper_enabled(kept), .reset_in_n(pin_rst_n), .hold_req_n(hold_n),
    .output_disable_n(off_n), .ext_address_bus_o(addr_o), .ext_address_lo_oe(lo_oe),
    .ext_address_hi_oe(hi_oe), .ext_data_bus_i(dbus_i), .ext_data_bus_o(dbus_o),
    .ext_data_bus_oe(d_oe), .ext_data_keep_en(keep_en), .hold_ack_n(hack_n),
    .irq_acknowledge_n(irq_acknowledge_n_n), .irq_acknowledge_oe(irq_acknowledge_n_oe));

  ext_mem_model i_mem (.sys_clk(sys_clk), .rst_n(rst_n), .mem_drive(mem_drive),
    .addr_lo(addr_o[15:0]), .data_o(dbus_o), .data_oe(d_oe), .keep_en(keep_en),
    .data_wire(dbus_i));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // inputs always change 1 ns after the edge
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic drive(input logic a, w, p, v, input logic [22:0] ad, input logic [15:0] wd);
    acc = a;
    wr = w;
    prog = p;
    vec = v;
    addr = ad;
    wdata = wd;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_write(input logic p, input logic [22:0] ad, input logic [15:0] wd);
    drive(1, 1, p, 0, ad, wd);
    step(1);
    check(addr_o[15:0], ad[15:0], "low address");
    check(lo_oe, 1, "low address enable");
    check(hi_oe, p, "high address enable");
    if (p) check(addr_o[22:16], ad[22:16], "high address");
    check(dbus_o, wd, "write data");
    check(d_oe, 1, "data enable");
    drive(0, 0, 0, 0, ad, wd);
    step(1);
    check(d_oe, 0, "data released");
    check(keep_en, keeper_on, "keeper drive");
    if (keeper_on) begin
      step(3);
      check(dbus_o, wd, "kept level");
      check(dbus_i, wd, "kept wire level");
    end
    $display("write test done");
  endtask
  task automatic t_keeper(input logic v);
    ks_wr = 1;
    ks_val = v;
    step(1);
    ks_wr = 0;
    keeper_on = v;
    check(kept, v, "keeper bit");
    $display("keeper test done");
  endtask
  task automatic t_read(input logic [22:0] ad);
    drive(1, 0, 0, 0, ad, 0);
    mem_drive = 1;
    step(5);
    check(rdata, ad[15:0] ^ 16'h5a5a, "read data");
    check(d_oe, 0, "no drive on read");
    mem_drive = 0;
    drive(0, 0, 0, 0, ad, 0);
    step(1);
    $display("read test done");
  endtask
  task automatic t_vector(input logic [22:0] ad);
    drive(1, 0, 1, 1, ad, 0);
    step(1);
    check(irq_acknowledge_n_n, 0, "acknowledge");
    check(addr_o[15:0], ad[15:0], "vector address");
    check(irq_acknowledge_n_oe, 1, "acknowledge enable");
    drive(0, 0, 0, 0, ad, 0);
    step(1);
    check(irq_acknowledge_n_n, 1, "acknowledge ends");
    $display("vector test done");
  endtask
  // float by output-disable or hold while a program write is pending
  task automatic t_float(input logic by_hold);
    if (by_hold) hold_n = 0;
    else off_n = 0;
    step(by_hold ? 4 : 1);
    drive(1, 1, 1, 0, 23'h7f0001, 16'hc3c3);
    step(by_hold ? 1 : 2);
    check(lo_oe, 0, "low address float");
    check(hi_oe, 0, "high address float");
    check(d_oe, 0, "data float");
    if (by_hold) check(hack_n, 0, "hold granted");
    else check(irq_acknowledge_n_oe, 0, "acknowledge float");
    drive(0, 0, 0, 0, 23'h0, 16'h0);
    hold_n = 1;
    off_n = 1;
    step(5);
    check(lo_oe, 1, "address back");
    $display("float test done");
  endtask
  task automatic t_pin_reset;
    pin_rst_n = 0;
    drive(1, 1, 0, 0, 23'h000055, 16'h1234);
    step(3);
    check(d_oe, 0, "data float in reset");
    pin_rst_n = 1;
    drive(0, 0, 0, 0, 23'h0, 16'h0);
    step(4);
    $display("pin reset test done");
  endtask
  // mid-run reset with the keepers on: the keeper bit must fall back to off
  task automatic t_reset;
    t_keeper(1);
    rst_n = 0;
    step(2);
    check(kept, 0, "keeper bit in reset");
    check(keep_en, 0, "keeper drive in reset");
    check(d_oe, 0, "data float in reset");
    check(irq_acknowledge_n_n, 1, "acknowledge idle in reset");
    check(hack_n, 1, "no grant in reset");
    rst_n = 1;
    keeper_on = 0;
    step(4);
    check(kept, 0, "keeper bit after reset");
    check(lo_oe, 1, "address back after reset");
    $display("reset test done");
  endtask

  // ----------------------------------------
  // clock, timeout, main sequence
  // ----------------------------------------
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 1000) begin
      miscompares++;
      $display("wrong value at %0t: run timed out", $time);
      tally_and_finish;
    end
  end
  initial begin
    rst_n = 0;
    drive(0, 0, 0, 0, 23'h0, 16'h0);
    {ks_wr, ks_val, mem_drive, keeper_on} = 4'h0;
    {pin_rst_n, hold_n, off_n} = 3'h7;
    step(10);
    rst_n = 1;
    check(kept, 0, "keeper bit after reset");
    step(4);
    t_write(1, 23'h5abcde, 16'ha55a);
    t_write(0, 23'h7f1234, 16'h0ff0);
    t_keeper(1);
    t_write(0, 23'h000f0f, 16'h3c3c);
    t_keeper(0);
    t_read(23'h00beef);
    t_vector(23'h00ffc4);
    t_float(0);
    t_float(1);
    t_pin_reset;
    t_reset;
    tally_and_finish;
  end
endmodule
